// ==== miau_core_model.sv ====
// Behavioural processor core facing the accept unit
`default_nettype none
module miau_core_model (
   input  wire logic        clk,           // Core clock
   input  wire logic        rst_n,         // Async reset, active low
   input  wire logic [15:0] vec_addr,      // Vector slot requested
   output logic             instr_last,    // Final cycle of instruction
   output logic [7:0]       status_hi,     // Status word high byte
   output logic [7:0]       status_lo,     // Status word low byte
   output logic [23:0]      pc_now,        // Return address
   output logic [7:0]       sp_now,        // Stack pointer
   output logic [7:0]       bank_now,      // Bank selector
   output logic [23:0]      vec_entry,     // Entry address from slot
   output logic [7:0]       vec_bank_code  // Bank code from slot
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] phase_ff; // Position in a four cycle instruction
   // -------------------------------------------------------------------
   // Instruction pacing; every instruction lasts four cycles
   // -------------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         phase_ff <= 2'h0;
      end else begin
         phase_ff <= phase_ff + 2'h1;
      end
   end
   assign instr_last = (phase_ff == 2'h3);
   // Fixed core state; bit 0 of the low byte is left clear for the master bit
   assign status_hi = 8'ha5;
   assign status_lo = 8'h5a;
   assign pc_now = 24'h012345;
   assign sp_now = 8'h80;
   assign bank_now = 8'h02;
   // Entry address follows the slot asked for, so a wrong slot shows up; bank code is fixed
   assign vec_entry = {8'h40, vec_addr};
   assign vec_bank_code = 8'h30;
endmodule
`default_nettype wire

// ==== miau_map.vh ====
// Address map, field positions, reset values and timing counts of the interrupt accept unit
`ifndef MIAU_MAP_VH
`define MIAU_MAP_VH
// -------------------------------------------------------------------------
// Register indices; the APB byte address is four times the index
// -------------------------------------------------------------------------
`define MIAU_IDX_UPPER      16'h002a
`define MIAU_IDX_MIDDLE     16'h002c
`define MIAU_IDX_MASTER_LOW 16'h003a
`define MIAU_IDX_LATCH_LOW  16'h003c
`define MIAU_IDX_LATCH_MID  16'h002e
`define MIAU_IDX_LATCH_UP   16'h002b
`define MIAU_IDX_STATUS     16'h0040
`define MIAU_IDX_BANK       16'h0041
// -------------------------------------------------------------------------
// Fields and reset values
// -------------------------------------------------------------------------
`define MIAU_MASTER_BIT     0
`define MIAU_LOW_MASK       16'hbf68
`define MIAU_UPPER_MASK     7'h7f
`define MIAU_RST_EN16       16'h0000
`define MIAU_RST_EN8        8'h00
`define MIAU_NSRC           39
// -------------------------------------------------------------------------
// Timing
// -------------------------------------------------------------------------
`define MIAU_ACCEPT_CYCLES  4'hc
`define MIAU_STACK_BYTES    8'h05
`endif

// ==== miau_prio.v ====
// Fixed priority picker over the pending and enabled sources
`default_nettype none
module miau_prio (
   input  wire [38:0] req,     // Enabled pending requests
   output reg         any,     // Some request present
   output reg  [5:0]  idx      // Lowest numbered request wins
);
   integer i;
   // -------------------------------------------------------------------------
   // Search from the top down so the lowest index is the last written
   // -------------------------------------------------------------------------
   always @* begin
      any = 1'b0;
      idx = 6'h00;
      for (i = 38; i >= 0; i = i - 1) begin
         if (req[i]) begin
            any = 1'b1;
            idx = i[5:0];
         end
      end
   end
endmodule
`default_nettype wire

// ==== miau_props.sv ====
// Concurrent checks on the ports of the interrupt accept unit
`default_nettype none
module miau_props (
   input wire logic        clk,            // Core clock
   input wire logic        rst_n,          // Async reset, active low
   input wire logic        instr_last,     // Sampling point
   input wire logic        ret_maskable,   // Maskable return pulse
   input wire logic        ret_nonmask,    // Non-maskable return pulse
   input wire logic [7:0]  sp_now,         // Core stack pointer
   input wire logic [7:0]  bank_now,       // Core bank selector
   input wire logic [23:0] vec_entry,      // Entry from vector slot
   input wire logic [7:0]  vec_bank_code,  // Bank code from vector slot
   input wire logic        accept_busy_ff, // Acceptance running
   input wire logic        push_we_ff,     // Stack write strobe
   input wire logic [7:0]  push_addr_ff,   // Stack write address
   input wire logic        sp_load_ff,     // Stack pointer load
   input wire logic [7:0]  sp_new_ff,      // New stack pointer
   input wire logic        pc_load_ff,     // Entry address load
   input wire logic [23:0] pc_new_ff,      // Entry address
   input wire logic        bank_load_ff,   // Bank selector load
   input wire logic [7:0]  bank_new_ff,    // New bank selector
   input wire logic        handler_go_ff,  // Handler start
   input wire logic [1:0]  nest_flag_ff    // Nesting level
);
   timeunit 1ns;
   timeprecision 1ps;
   // -------------------------------------------------------------------
   // Clocking and named steps of acceptance
   // -------------------------------------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Busy for at least eleven samples; exact edge of drop left to design
   sequence busy_run_s; accept_busy_ff[*8] ##1 accept_busy_ff[*3]; endsequence
   // Five back to back stack writes, then quiet
   sequence push_run_s; push_we_ff[*5] ##1 !push_we_ff; endsequence
   // -------------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------------
   accept_len_a: assert property (
      $rose(accept_busy_ff) |-> busy_run_s ##[0:2] handler_go_ff)
      else $error("acceptance length wrong");
   entry_sample_a: assert property (
      $rose(accept_busy_ff) |-> $past(instr_last))
      else $error("acceptance started off the sampling cycle");
   push_run_a: assert property (
      $rose(push_we_ff) |-> push_addr_ff == sp_now ##0 (accept_busy_ff throughout push_run_s))
      else $error("stack push run wrong");
   push_down_a: assert property (
      push_we_ff && $past(push_we_ff) |-> push_addr_ff == $past(push_addr_ff) - 8'h01)
      else $error("stack address not descending");
   sp_drop_a: assert property (
      sp_load_ff |-> sp_new_ff == sp_now - 8'h05)
      else $error("stack pointer not lowered by five");
   pc_entry_a: assert property (
      pc_load_ff |-> pc_new_ff == vec_entry && accept_busy_ff)
      else $error("entry address wrong");
   bank_add_a: assert property (
      bank_load_ff && accept_busy_ff |->
         bank_new_ff == {bank_now[7:4], bank_now[3:0] + vec_bank_code[7:4]})
      else $error("bank selector sum wrong");
   nest_up_a: assert property (
      $rose(accept_busy_ff) && nest_flag_ff == 2'b00 |-> ##[9:12] nest_flag_ff == 2'b01)
      else $error("nesting level not raised");
   ret_bank_a: assert property (
      (ret_maskable || ret_nonmask) && !accept_busy_ff && nest_flag_ff != 2'b00 |->
         ##[1:3] bank_load_ff)
      else $error("bank selector not restored on return");
endmodule
bind miau_top miau_props chk_u (.clk, .rst_n, .instr_last, .ret_maskable, .ret_nonmask,
   .sp_now, .bank_now, .vec_entry, .vec_bank_code, .accept_busy_ff, .push_we_ff,
   .push_addr_ff, .sp_load_ff, .sp_new_ff, .pc_load_ff, .pc_new_ff, .bank_load_ff,
   .bank_new_ff, .handler_go_ff, .nest_flag_ff);
`default_nettype wire

// ==== miau_tb.sv ====
// Self-checking bench for the interrupt accept unit
`default_nettype none
`include "miau_map.vh"
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [15:0] paddr = 16'h0000;              // APB address
   logic [31:0] pwdata = 32'h0, prdata, rdat;  // APB data
   logic [38:0] src_req = '0;                  // Source pulses
   logic [4:0]  ctl = 5'h00;                   // Return m/n, nmi entry, set, clear
   logic        pready, pslverr, rerr, instr_last, busy, go, push_we;
   logic [7:0]  st_hi, st_lo, sp, bank, bcode, push_data;
   logic [23:0] pc, entry;
   logic [15:0] vaddr;
   logic [5:0]  src;
   logic [1:0]  nest;
   logic [7:0]  pushes[$];                     // Stacked bytes seen
   logic [7:0]  push_exp[5] = '{8'ha5, 8'h5b, 8'h01, 8'h23, 8'h45};
   int          fails = 0, n_checks = 0, cyc = 0, k, n_acc = 0;
   miau_top dut_u (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .src_req(src_req), .instr_last(instr_last),
      .ret_maskable(ctl[4]), .ret_nonmask(ctl[3]), .nmi_entry(ctl[2]),
      .set_master(ctl[1]), .clr_master(ctl[0]), .status_hi(st_hi), .status_lo(st_lo),
      .pc_now(pc), .sp_now(sp), .bank_now(bank), .vec_entry(entry), .vec_bank_code(bcode),
      .accept_busy_ff(busy), .accept_src_ff(src), .vec_addr_ff(vaddr),
      .push_we_ff(push_we), .push_addr_ff(), .push_data_ff(push_data), .sp_load_ff(),
      .sp_new_ff(), .pc_load_ff(), .pc_new_ff(), .bank_load_ff(), .bank_new_ff(),
      .handler_go_ff(go), .nest_flag_ff(nest));
   miau_core_model core_u (.clk(clk), .rst_n(rst_n), .vec_addr(vaddr),
      .instr_last(instr_last), .status_hi(st_hi), .status_lo(st_lo), .pc_now(pc),
      .sp_now(sp), .bank_now(bank), .vec_entry(entry), .vec_bank_code(bcode));
   // -------------------------------------------------------------------
   // Clock, monitors and hang guard
   // -------------------------------------------------------------------
   always #5 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (push_we === 1'b1) pushes.push_back(push_data);
      if (go === 1'b1) n_acc++;
      // Whole run needs well under a thousand cycles
      if (cyc == 5000) begin
         fails++;
         test_done();
      end
   end
   // -------------------------------------------------------------------
   // Tasks
   // -------------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // One APB transfer to register index a; byte address is four times it
   task automatic apb(input logic [15:0] a, input logic w, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      paddr <= {a[13:0], 2'b00};
      pwrite <= w;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      chk("pready", 32'h1, 32'(pready));
   endtask
   task automatic rd(input logic [15:0] a, input logic [31:0] e, input string nm);
      apb(a, 1'b0, 32'h0);
      chk(nm, e, rdat);
   endtask
   // Core pulses and source pulses last one cycle
   task automatic pulse(input logic [4:0] p);
      @(posedge clk);
      ctl <= p;
      @(posedge clk);
      ctl <= 5'h00;
   endtask
   task automatic req(input logic [38:0] r);
      @(posedge clk);
      src_req <= r;
      @(posedge clk);
      src_req <= '0;
   endtask
   // Bounded waits for acceptance start and handler start
   task automatic wait_go(input logic [5:0] s);
      k = 0;
      while (busy !== 1'b1 && k < 62) begin
         @(posedge clk);
         k++;
      end
      chk("acceptance start", 32'h1, 32'(busy));
      k = 0;
      while (go !== 1'b1 && k < 20) begin
         @(posedge clk);
         k++;
      end
      chk("handler start", 32'h1, 32'(go));
      chk("accepted source", 32'(s), 32'(src));
      chk("vector slot", 32'(s) * 32'h2, 32'(vaddr));
      @(posedge clk);
   endtask
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // -------------------------------------------------------------------
   // Main sequence
   // -------------------------------------------------------------------
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      rd(`MIAU_IDX_MASTER_LOW, 32'h0, "master low reset");
      rd(`MIAU_IDX_MIDDLE, 32'h0, "middle reset");
      rd(`MIAU_IDX_UPPER, 32'h0, "upper reset");
      apb(16'h0100, 1'b0, 32'h0);
      chk("unmapped error", 32'h1, 32'(rerr));
      apb(`MIAU_IDX_UPPER, 1'b1, 32'hff);
      rd(`MIAU_IDX_UPPER, 32'h7f, "upper enables");
      apb(`MIAU_IDX_MIDDLE, 1'b1, 32'ha5a5);
      rd(`MIAU_IDX_MIDDLE, 32'ha5a5, "middle enables");
      // Enable written with master still clear; request must wait
      apb(`MIAU_IDX_MASTER_LOW, 1'b1, 32'h20);
      req(39'h20);
      repeat (20) @(posedge clk);
      chk("accepts while masked", 32'h0, 32'(n_acc));
      rd(`MIAU_IDX_LATCH_LOW, 32'h20, "latch held");
      pulse(5'h02);
      wait_go(6'd5);
      rd(`MIAU_IDX_MASTER_LOW, 32'h20, "master after accept");
      rd(`MIAU_IDX_LATCH_LOW, 32'h0, "latch after accept");
      chk("nest level", 32'h1, 32'(nest));
      chk("pushed count", 32'h5, 32'(pushes.size()));
      for (int i = 0; i < 5; i++) chk("pushed byte", 32'(push_exp[i]), 32'(pushes[i]));
      // Inside the handler: enables edited while master is clear
      apb(`MIAU_IDX_MASTER_LOW, 1'b1, 32'h60);
      req(39'h160);
      repeat (20) @(posedge clk);
      chk("accepts in handler", 32'h1, 32'(n_acc));
      pulse(5'h10);
      wait_go(6'd5);
      pulse(5'h10);
      wait_go(6'd6);
      rd(`MIAU_IDX_LATCH_LOW, 32'h100, "disabled source latch");
      apb(`MIAU_IDX_LATCH_LOW, 1'b1, 32'hfeff);
      rd(`MIAU_IDX_LATCH_LOW, 32'h0, "latch cleared");
      apb(`MIAU_IDX_MASTER_LOW, 1'b1, 32'h20);
      pulse(5'h10);
      rd(`MIAU_IDX_MASTER_LOW, 32'h21, "master after return");
      chk("nest after return", 32'h0, 32'(nest));
      pulse(5'h04);
      pulse(5'h01);
      rd(`MIAU_IDX_MASTER_LOW, 32'h20, "master cleared");
      pulse(5'h08);
      rd(`MIAU_IDX_MASTER_LOW, 32'h21, "master after nmi return");
      test_done();
   end
endmodule
`default_nettype wire

// ==== miau_top.v ====
// Maskable interrupt enable, latch and acceptance sequencer with APB registers
`default_nettype none
`include "miau_map.vh"
// Behaviour
// - Per-source enable bit gates its acceptance
// - Master enable bit zero blocks all
// - Request latch holds until accepted or cleared
// - Acceptance sequence lasts twelve machine cycles
// - Service ends on either return kind
// - Acceptance clears master enable first
// - Acceptance clears accepted source latch
// - Push five status and PC bytes
// - Load PC from vector slot
// - Add bank code upper nibble to selector
// - Increment nesting counter then run handler
// - Start acceptance within 62 oscillator periods
// - No acceptance while master is zero
// - Save only PC and status word
// - Returns restore bank selector automatically
// - Reset clears every source enable
// - Reset clears master enable
// - Maskable return sets master enable
// - Sample requests in instruction final cycle
module miau_top (
   input  wire        clk,              // Core clock 100 MHz
   input  wire        rst_n,            // Asynchronous reset, active low
   input  wire        psel,             // APB select
   input  wire        penable,          // APB access phase
   input  wire        pwrite,           // APB write
   input  wire [15:0] paddr,            // APB byte address
   input  wire [31:0] pwdata,           // APB write data
   output reg  [31:0] prdata,           // APB read data
   output reg         pready,           // APB ready
   output reg         pslverr,          // APB error on unmapped address
   input  wire [38:0] src_req,          // Request pulses from sources, same clock
   input  wire        instr_last,       // Final cycle of current instruction
   input  wire        ret_maskable,     // Maskable return executed, pulse
   input  wire        ret_nonmask,      // Non-maskable return executed, pulse
   input  wire        nmi_entry,        // Pseudo non-maskable accepted, pulse
   input  wire        set_master,       // Set master enable instruction, pulse
   input  wire        clr_master,       // Clear master enable instruction, pulse
   input  wire [7:0]  status_hi,        // Status word high byte
   input  wire [7:0]  status_lo,        // Status word low byte without master bit
   input  wire [23:0] pc_now,           // Return address from core
   input  wire [7:0]  sp_now,           // Stack pointer from core
   input  wire [7:0]  bank_now,         // Current bank selector
   input  wire [23:0] vec_entry,        // Entry address read from vector slot
   input  wire [7:0]  vec_bank_code,    // Bank control code from vector slot
   output reg         accept_busy_ff,   // Acceptance sequence running
   output reg  [5:0]  accept_src_ff,    // Source being accepted
   output reg  [15:0] vec_addr_ff,      // Vector slot address requested
   output reg         push_we_ff,       // Stack byte write strobe
   output reg  [7:0]  push_addr_ff,     // Stack byte address
   output reg  [7:0]  push_data_ff,     // Stack byte data
   output reg         sp_load_ff,       // Load new stack pointer, pulse
   output reg  [7:0]  sp_new_ff,        // New stack pointer
   output reg         pc_load_ff,       // Load entry address, pulse
   output reg  [23:0] pc_new_ff,        // Entry address
   output reg         bank_load_ff,     // Load bank selector, pulse
   output reg  [7:0]  bank_new_ff,      // New bank selector
   output reg         handler_go_ff,    // Start handler instruction, pulse
   output reg  [1:0]  nest_flag_ff      // Nesting level seen by software
);
   // -------------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------------
   localparam ST_IDLE = 1'b0;           // Waiting for a sampling point
   localparam ST_ACC  = 1'b1;           // Acceptance running
   reg         state_ff;                // Sequencer state
   reg  [3:0]  cyc_ff;                  // Cycle in acceptance
   reg         master_ff;               // Master enable
   reg  [38:0] enable_ff;               // Per-source enables, bits 0..2, 4, 7 and 14 unused
   reg  [38:0] latch_ff;                // Request latches
   reg  [3:0]  nest_ff;                 // Nesting counter
   reg  [7:0]  sp_ff;                   // Stack pointer snapshot
   reg  [7:0]  bank_save_ff [0:15];     // Bank selector per nest level
   reg         nmi_master_ff;           // Master state saved on pseudo NMI
   wire        any_req;                 // Some source eligible
   wire [5:0]  win_idx;                 // Winning source
   wire        wr;                      // APB write access
   wire        rd;                      // APB read access
   wire [38:0] low_mask;                // Implemented bits of all three enable registers
   wire [15:0] widx;                    // Register index, all ones if unaligned
   reg  [38:0] nxt_latch;               // Next request latch value
   assign wr = psel & penable & pwrite;
   assign rd = psel & penable & ~pwrite;
   assign low_mask = {`MIAU_UPPER_MASK, 16'hffff, `MIAU_LOW_MASK};
   // Unaligned byte addresses fall on an index no register uses, so they error
   assign widx = (paddr[1:0] == 2'b00) ? {2'b00, paddr[15:2]} : 16'hffff;

   miau_prio u_prio (
      .req (latch_ff & enable_ff & low_mask),
      .any (any_req),
      .idx (win_idx)
   );

   // Mapped address test shared by read and write paths
   function mapped;
      input [15:0] a;
      begin
         mapped = (a == `MIAU_IDX_UPPER) | (a == `MIAU_IDX_MIDDLE) |
                  (a == `MIAU_IDX_MASTER_LOW) | (a == `MIAU_IDX_LATCH_LOW) |
                  (a == `MIAU_IDX_LATCH_MID) | (a == `MIAU_IDX_LATCH_UP) |
                  (a == `MIAU_IDX_STATUS) | (a == `MIAU_IDX_BANK);
      end
   endfunction

   // -------------------------------------------------------------------------
   // APB answer: single access with one wait state, error on unmapped
   // -------------------------------------------------------------------------
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata  <= 32'h00000000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         // Ready is registered, so each access lasts two access cycles
         pready  <= psel & penable & ~pready;
         pslverr <= psel & penable & ~pready & ~mapped(widx);
         if (rd & ~pready) begin
            case (widx)
               `MIAU_IDX_UPPER:      prdata <= {25'h0, enable_ff[38:32]};
               `MIAU_IDX_MIDDLE:     prdata <= {16'h0, enable_ff[31:16]};
               `MIAU_IDX_MASTER_LOW: prdata <= {16'h0, (enable_ff[15:0] & `MIAU_LOW_MASK) |
                                                 {15'h0, master_ff}};
               `MIAU_IDX_LATCH_LOW:  prdata <= {16'h0, latch_ff[15:0] & `MIAU_LOW_MASK};
               `MIAU_IDX_LATCH_MID:  prdata <= {16'h0, latch_ff[31:16]};
               `MIAU_IDX_LATCH_UP:   prdata <= {25'h0, latch_ff[38:32]};
               `MIAU_IDX_STATUS:     prdata <= {23'h0, state_ff, nest_ff, cyc_ff};
               `MIAU_IDX_BANK:       prdata <= {26'h0, accept_src_ff};
               default:              prdata <= 32'h00000000;
            endcase
         end
      end
   end

   // -------------------------------------------------------------------------
   // Enables and master flag
   // -------------------------------------------------------------------------
   // Acceptance clears the master bit before any software write lands; hardware wins.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         enable_ff     <= {`MIAU_NSRC{1'b0}};
         master_ff     <= 1'b0;
         nmi_master_ff <= 1'b0;
      end else begin
         if (wr & pready & ~pslverr) begin
            case (widx)
               `MIAU_IDX_UPPER:  enable_ff[38:32] <= pwdata[6:0];
               `MIAU_IDX_MIDDLE: enable_ff[31:16] <= pwdata[15:0];
               `MIAU_IDX_MASTER_LOW: begin
                  enable_ff[15:0] <= pwdata[15:0] & `MIAU_LOW_MASK;
                  master_ff       <= pwdata[`MIAU_MASTER_BIT];
               end
               default: ;
            endcase
         end
         if (set_master)
            master_ff <= 1'b1;
         if (clr_master)
            master_ff <= 1'b0;
         if (nmi_entry) begin
            nmi_master_ff <= master_ff;
            master_ff     <= 1'b0;
         end
         if (ret_maskable)
            master_ff <= 1'b1;
         if (ret_nonmask & nmi_master_ff)
            master_ff <= 1'b1;
         if (state_ff == ST_IDLE && instr_last && master_ff && any_req)
            master_ff <= 1'b0;
      end
   end

   // -------------------------------------------------------------------------
   // Request latches: set by sources, cleared by accept or software zero write
   // -------------------------------------------------------------------------
   // Next value; a source pulse in the same cycle as a clear wins
   always @* begin
      nxt_latch = latch_ff;
      if (wr & pready & ~pslverr) begin
         case (widx)
            `MIAU_IDX_LATCH_LOW: nxt_latch[15:0]  = latch_ff[15:0] & pwdata[15:0];
            `MIAU_IDX_LATCH_MID: nxt_latch[31:16] = latch_ff[31:16] & pwdata[15:0];
            `MIAU_IDX_LATCH_UP:  nxt_latch[38:32] = latch_ff[38:32] & pwdata[6:0];
            default: ;
         endcase
      end
      if (state_ff == ST_ACC && cyc_ff == 4'h1)
         nxt_latch[accept_src_ff] = 1'b0;
      nxt_latch = nxt_latch | src_req;
   end

   // Latch register itself
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         latch_ff <= {`MIAU_NSRC{1'b0}};
      end else begin
         latch_ff <= nxt_latch;
      end
   end

   // -------------------------------------------------------------------------
   // Acceptance sequencer, twelve cycles
   // -------------------------------------------------------------------------
   // Sampling only at instr_last keeps the latency bound to one instruction.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff       <= ST_IDLE;
         cyc_ff         <= 4'h0;
         accept_busy_ff <= 1'b0;
         accept_src_ff  <= 6'h00;
         vec_addr_ff    <= 16'h0000;
         push_we_ff     <= 1'b0;
         push_addr_ff   <= 8'h00;
         push_data_ff   <= 8'h00;
         sp_load_ff     <= 1'b0;
         sp_new_ff      <= 8'h00;
         sp_ff          <= 8'h00;
         pc_load_ff     <= 1'b0;
         pc_new_ff      <= 24'h000000;
         handler_go_ff  <= 1'b0;
      end else begin
         push_we_ff    <= 1'b0;
         sp_load_ff    <= 1'b0;
         pc_load_ff    <= 1'b0;
         handler_go_ff <= 1'b0;
         case (state_ff)
            ST_IDLE: begin
               if (instr_last && master_ff && any_req) begin
                  state_ff       <= ST_ACC;
                  cyc_ff         <= 4'h1;
                  accept_busy_ff <= 1'b1;
                  accept_src_ff  <= win_idx;
                  vec_addr_ff    <= {9'h000, win_idx, 1'b0};
                  sp_ff          <= sp_now;
               end
            end
            ST_ACC: begin
               cyc_ff <= cyc_ff + 4'h1;
               // Only PC and status bytes are stacked; general registers stay put
               if (cyc_ff >= 4'h2 && cyc_ff <= 4'h6) begin
                  push_we_ff   <= 1'b1;
                  push_addr_ff <= sp_ff - {4'h0, cyc_ff - 4'h2};
                  case (cyc_ff)
                     4'h2:    push_data_ff <= status_hi;
                     4'h3:    push_data_ff <= {status_lo[7:1], 1'b1};
                     4'h4:    push_data_ff <= pc_now[23:16];
                     4'h5:    push_data_ff <= pc_now[15:8];
                     default: push_data_ff <= pc_now[7:0];
                  endcase
               end
               if (cyc_ff == 4'h7) begin
                  sp_load_ff <= 1'b1;
                  sp_new_ff  <= sp_ff - `MIAU_STACK_BYTES;
               end
               if (cyc_ff == 4'h9) begin
                  pc_load_ff <= 1'b1;
                  pc_new_ff  <= vec_entry;
               end
               if (cyc_ff == `MIAU_ACCEPT_CYCLES) begin
                  state_ff       <= ST_IDLE;
                  cyc_ff         <= 4'h0;
                  accept_busy_ff <= 1'b0;
                  handler_go_ff  <= 1'b1;
               end
            end
            default: state_ff <= ST_IDLE;
         endcase
      end
   end

   // -------------------------------------------------------------------------
   // Bank selector and nesting counter
   // -------------------------------------------------------------------------
   // Underflow is not detected: a stray return leaves the counter at zero.
   integer k;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         nest_ff      <= 4'h0;
         nest_flag_ff <= 2'b00;
         bank_load_ff <= 1'b0;
         bank_new_ff  <= 8'h00;
         for (k = 0; k < 16; k = k + 1)
            bank_save_ff[k] <= 8'h00;
      end else begin
         bank_load_ff <= 1'b0;
         if (state_ff == ST_ACC && cyc_ff == 4'ha) begin
            bank_save_ff[nest_ff] <= bank_now;
            bank_load_ff <= 1'b1;
            bank_new_ff  <= {bank_now[7:4], bank_now[3:0] + vec_bank_code[7:4]};
         end
         if (state_ff == ST_ACC && cyc_ff == 4'hb) begin
            nest_ff      <= nest_ff + 4'h1;
            nest_flag_ff <= (nest_ff == 4'h0) ? 2'b01 : (nest_ff == 4'h1) ? 2'b10 : 2'b11;
         end else if ((ret_maskable | ret_nonmask) && nest_ff != 4'h0) begin
            nest_ff      <= nest_ff - 4'h1;
            nest_flag_ff <= (nest_ff == 4'h1) ? 2'b00 : (nest_ff == 4'h2) ? 2'b01 :
                            (nest_ff == 4'h3) ? 2'b10 : 2'b11;
            bank_load_ff <= 1'b1;
            bank_new_ff  <= bank_save_ff[nest_ff - 4'h1];
         end
      end
   end
endmodule
`default_nettype wire
